// ### rtl/ptd_decoder.sv
// Pulse train reference decoder: filters the two reference lines, decodes
// them per the latched pulse form and drives a signed position accumulator.
// Assumes the two reference lines are asynchronous pins already converted to
// logic levels; configuration inputs are sampled only at restart.
//
// Overview of operation
// - Decode pulses only when control method selects position control.
// - Pulse form code picks sign/pulse, forward/reverse or quadrature encoding.
// - Positive sign mode: direction high counts forward, low counts reverse.
// - Negative sign mode: direction low counts forward, high counts reverse.
// - Positive forward/reverse: pulse on either line steps; idle lines low.
// - Negative forward/reverse: same as positive, active-low, idle high.
// - Quadrature: B leading A is forward, B lagging A is reverse.
// - Quadrature codes give one, two or four counts per input cycle.
// - Filter code selects 1 Mpps, 200 kpps or 4 Mpps input filter.
// - Open-collector: conducting transistor reads high, off reads low.
`timescale 1ns/1ps
module ptd_decoder
	import ptd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Configuration, latched at restart
	input wire logic [3:0] control_method_select_i,
	input wire logic [3:0] pulse_form_select_i,
	input wire logic [3:0] filter_select_i,
	// Reference lines: pulse_line / phase A / reverse, and sign / phase B / forward
	input wire logic pulse_line_i,
	input wire logic sign_line_i,
	// Decoded output
	output logic fwd_step_o,
	output logic rev_step_o,
	output logic active_o,
	output logic cfg_error_o,
	output logic signed [POS_W-1:0] position_o
);
	typedef enum logic [1:0] {
		PTD_ST_RESTART = 2'b00,
		PTD_ST_RUN = 2'b01,
		PTD_ST_IDLE = 2'b10
	} ptd_state_e;

	ptd_state_e state_r;
	logic [3:0] form_r;
	logic [3:0] filt_r;
	logic [FILT_W-1:0] len_r;
	logic prev_a_r, prev_b_r;
	logic fwd_nxt, rev_nxt;
	logic line_a, line_b;

	ptd_line_if lines ();

	// Open-collector logic sense is absorbed by the receiver: a conducting
	// transistor already arrives as a high level, so no inversion here.
	ptd_filter u_filter (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_a_i(pulse_line_i),
		.pin_b_i(sign_line_i),
		.len_i(len_r),
		.out(lines)
	);

	assign line_a = lines.line_a;
	assign line_b = lines.line_b;

	function automatic logic form_valid(input logic [3:0] f);
		form_valid = (f <= FORM_FWDREV_NEG);
	endfunction

	function automatic logic [FILT_W-1:0] filt_len(input logic [3:0] f);
		case (f)
			FILT_OPEN_200K: filt_len = FILT_W'(FILT_200K_CYC);
			FILT_LINE_4M: filt_len = FILT_W'(FILT_4M_CYC);
			default: filt_len = FILT_W'(FILT_1M_CYC);
		endcase
	endfunction

	// Quadrature sense: B leading A leaves the lines equal after an A edge
	function automatic logic quad_fwd(input logic a_moved, input logic a, input logic b);
		quad_fwd = a_moved ? (a == b) : (a != b);
	endfunction

	// Restart latch: settings take effect only through a reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_r <= PTD_ST_RESTART;
			form_r <= FORM_SIGN_POS;
			filt_r <= FILT_LINE_1M;
			len_r <= 7'h00;
			cfg_error_o <= 1'b0;
		end else if (state_r == PTD_ST_RESTART) begin
			form_r <= pulse_form_select_i;
			filt_r <= filter_select_i;
			len_r <= filt_len(filter_select_i);
			cfg_error_o <= !form_valid(pulse_form_select_i) || (filter_select_i > FILT_LINE_4M);
			if (control_method_select_i == CTRL_POSITION && form_valid(pulse_form_select_i)) begin
				state_r <= PTD_ST_RUN;
			end else begin
				state_r <= PTD_ST_IDLE;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prev_a_r <= 1'b0;
			prev_b_r <= 1'b0;
		end else begin
			prev_a_r <= line_a;
			prev_b_r <= line_b;
		end
	end

	// Step decode by pulse form
	always_comb begin
		logic rise_a, fall_a, rise_b, fall_b, edge_a, edge_b;
		rise_a = line_a && !prev_a_r;
		fall_a = !line_a && prev_a_r;
		rise_b = line_b && !prev_b_r;
		fall_b = !line_b && prev_b_r;
		edge_a = rise_a || fall_a;
		edge_b = rise_b || fall_b;
		fwd_nxt = 1'b0;
		rev_nxt = 1'b0;
		if (state_r == PTD_ST_RUN) begin
			case (form_r)
				FORM_SIGN_POS: begin
					fwd_nxt = rise_a && line_b;
					rev_nxt = rise_a && !line_b;
				end
				FORM_SIGN_NEG: begin
					fwd_nxt = fall_a && !line_b;
					rev_nxt = fall_a && line_b;
				end
				FORM_FWDREV_POS: begin
					fwd_nxt = rise_b && !rise_a;
					rev_nxt = rise_a && !rise_b;
				end
				FORM_FWDREV_NEG: begin
					fwd_nxt = fall_b && !fall_a;
					rev_nxt = fall_a && !fall_b;
				end
				FORM_QUAD_X1: begin
					// One count per cycle, on A rising
					fwd_nxt = rise_a && line_b;
					rev_nxt = rise_a && !line_b;
				end
				FORM_QUAD_X2: begin
					// Every A edge counts; B only gives the sense
					fwd_nxt = edge_a && quad_fwd(1'b1, line_a, line_b);
					rev_nxt = edge_a && !quad_fwd(1'b1, line_a, line_b);
				end
				FORM_QUAD_X4: begin
					// Both lines moving at once is a lost step; dropped on purpose
					if (edge_a ^ edge_b) begin
						fwd_nxt = quad_fwd(edge_a, line_a, line_b);
						rev_nxt = !quad_fwd(edge_a, line_a, line_b);
					end
				end
				default: begin
					fwd_nxt = 1'b0;
					rev_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fwd_step_o <= 1'b0;
			rev_step_o <= 1'b0;
			active_o <= 1'b0;
		end else begin
			fwd_step_o <= fwd_nxt;
			rev_step_o <= rev_nxt;
			active_o <= (state_r == PTD_ST_RUN);
		end
	end

	// Position accumulator, wraps in two's complement
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			position_o <= POS_RESET;
		end else if (fwd_nxt) begin
			position_o <= position_o + 32'sh0000_0001;
		end else if (rev_nxt) begin
			position_o <= position_o - 32'sh0000_0001;
		end
	end

	a_idle_no_steps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r != PTD_ST_RUN |=> !fwd_step_o && !rev_step_o)
		else $error("step while not in position control");
	a_steps_exclusive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(fwd_step_o && rev_step_o))
		else $error("forward and reverse step together");
	a_fwd_increments: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		fwd_nxt |=> position_o == $past(position_o) + 32'sh0000_0001)
		else $error("forward step did not increment");
	a_rev_decrements: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rev_nxt |=> position_o == $past(position_o) - 32'sh0000_0001)
		else $error("reverse step did not decrement");
	a_sign_pos_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_SIGN_POS && line_a && !prev_a_r
		|=> fwd_step_o == $past(line_b))
		else $error("positive sign direction wrong");
	a_sign_neg_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_SIGN_NEG && !line_a && prev_a_r
		|=> rev_step_o == $past(line_b))
		else $error("negative sign direction wrong");
	a_fwdrev_pos: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_FWDREV_POS && line_b && !prev_b_r
		&& !(line_a && !prev_a_r) |=> fwd_step_o)
		else $error("forward line pulse not counted");
	a_fwdrev_neg: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_FWDREV_NEG && !line_a && prev_a_r
		&& !(!line_b && prev_b_r) |=> rev_step_o)
		else $error("active-low reverse pulse not counted");
	a_quad_x1_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		form_r == FORM_QUAD_X1 && fwd_nxt |-> line_a && !prev_a_r && line_b)
		else $error("x1 forward count not on A rising with B high");
	a_quad_x4_b: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_QUAD_X4 && (line_b != prev_b_r)
		&& (line_a == prev_a_r) |=> fwd_step_o || rev_step_o)
		else $error("x4 missed B edge");
	a_filter_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r != PTD_ST_RESTART && filt_r == FILT_OPEN_200K
		|-> len_r == FILT_W'(FILT_200K_CYC))
		else $error("open-collector filter length wrong");

	// Opposite senses and quiet lines: a swapped or stray count
	// would pass the one-sense checks above unnoticed
	a_sign_pos_rev: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_SIGN_POS && line_a && !prev_a_r
		|=> rev_step_o == !$past(line_b))
		else $error("positive sign reverse sense wrong");
	a_sign_neg_fwd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_SIGN_NEG && !line_a && prev_a_r
		|=> fwd_step_o == !$past(line_b))
		else $error("negative sign forward sense wrong");
	a_sign_b_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		form_r == FORM_SIGN_POS && !(line_a && !prev_a_r)
		|=> !fwd_step_o && !rev_step_o)
		else $error("sign mode counted without a pulse edge");
	a_fwdrev_pos_rev: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_FWDREV_POS && line_a && !prev_a_r
		&& !(line_b && !prev_b_r) |=> rev_step_o)
		else $error("reverse line pulse not counted");
	a_fwdrev_neg_fwd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_FWDREV_NEG && !line_b && prev_b_r
		&& !(!line_a && prev_a_r) |=> fwd_step_o)
		else $error("active-low forward pulse not counted");
	a_quad_x1_rev: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		form_r == FORM_QUAD_X1 && rev_nxt |-> line_a && !prev_a_r && !line_b)
		else $error("x1 reverse count not on A rising with B low");
	a_x1_b_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		form_r == FORM_QUAD_X1 && !(line_a && !prev_a_r)
		|=> !fwd_step_o && !rev_step_o)
		else $error("x1 counted off an A rising edge");
	a_quad_x2_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_QUAD_X2 && (line_a != prev_a_r)
		|=> (fwd_step_o || rev_step_o) && fwd_step_o == $past(line_a == line_b))
		else $error("x2 A edge sense wrong or missed");
	a_x2_b_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		form_r == FORM_QUAD_X2 && (line_a == prev_a_r)
		|=> !fwd_step_o && !rev_step_o)
		else $error("x2 counted without an A edge");
	a_quad_x4_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RUN && form_r == FORM_QUAD_X4 && (line_a != prev_a_r)
		&& (line_b == prev_b_r) |=> fwd_step_o == $past(line_a == line_b))
		else $error("x4 A edge sense wrong");

	// Latched config holds until the next restart; accumulator holds without a step
	a_run_needs_pos: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RESTART && control_method_select_i != CTRL_POSITION
		|=> state_r == PTD_ST_IDLE)
		else $error("decoder ran outside position control");
	a_cfg_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == PTD_ST_RESTART |=> cfg_error_o ==
		($past(pulse_form_select_i) > FORM_FWDREV_NEG
		|| $past(filter_select_i) > FILT_LINE_4M))
		else $error("config error flag wrong");
	a_active_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		active_o |=> active_o)
		else $error("decoder stopped without a restart");
	a_cfg_error_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cfg_error_o |=> cfg_error_o)
		else $error("config error dropped without a restart");
	a_position_still: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!fwd_nxt && !rev_nxt |=> position_o == $past(position_o))
		else $error("position moved without a step");

	c_sign_fwd: cover property (@(posedge ref_clk_i) form_r == FORM_SIGN_POS && fwd_step_o);
	c_quad_rev: cover property (@(posedge ref_clk_i) form_r == FORM_QUAD_X4 && rev_step_o);
	c_fwdrev_neg: cover property (@(posedge ref_clk_i) form_r == FORM_FWDREV_NEG && fwd_step_o);
	c_idle: cover property (@(posedge ref_clk_i) state_r == PTD_ST_IDLE);
	c_quad_x2_fwd: cover property (@(posedge ref_clk_i) form_r == FORM_QUAD_X2 && fwd_step_o);
endmodule

// ### rtl/ptd_filter.sv
// Two-line synchroniser and glitch filter for the reference inputs.
// Assumes raw pins are asynchronous to ref_clk_i; len_i is static after restart.
`timescale 1ns/1ps
module ptd_filter
	import ptd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Raw lines and filter length
	input wire logic pin_a_i,
	input wire logic pin_b_i,
	input wire logic [FILT_W-1:0] len_i,
	// Filtered lines
	ptd_line_if.src out
);
	logic [1:0] sa_r, sb_r;
	logic [FILT_W-1:0] ca_r, cb_r;
	logic fa_r, fb_r;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sa_r <= 2'h0;
			sb_r <= 2'h0;
		end else begin
			sa_r <= {sa_r[0], pin_a_i};
			sb_r <= {sb_r[0], pin_b_i};
		end
	end

	// A level is accepted only after staying stable for len_i + 1 cycles
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ca_r <= 7'h00;
			fa_r <= 1'b0;
		end else if (sa_r[1] == fa_r) begin
			ca_r <= 7'h00;
		end else if (ca_r >= len_i) begin
			fa_r <= sa_r[1];
			ca_r <= 7'h00;
		end else begin
			ca_r <= ca_r + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cb_r <= 7'h00;
			fb_r <= 1'b0;
		end else if (sb_r[1] == fb_r) begin
			cb_r <= 7'h00;
		end else if (cb_r >= len_i) begin
			fb_r <= sb_r[1];
			cb_r <= 7'h00;
		end else begin
			cb_r <= cb_r + 7'h01;
		end
	end

	assign out.line_a = fa_r;
	assign out.line_b = fb_r;
endmodule

// ### rtl/ptd_line_if.sv
// Interface carrying filtered pulse lines between the filter and the decoder.
// Assumes both ends run on ref_clk_i.
`timescale 1ns/1ps
interface ptd_line_if;
	logic line_a;
	logic line_b;
	modport src (output line_a, output line_b);
	modport dst (input line_a, input line_b);
endinterface

// ### rtl/ptd_pkg.sv
// Package for the pulse train reference decoder.
// Assumes a single 100 MHz clock domain; config is latched at restart.
package ptd_pkg;
	// Control method code that enables position control
	localparam logic [3:0] CTRL_POSITION = 4'h1;
	// Pulse form codes
	localparam logic [3:0] FORM_SIGN_POS = 4'h0;
	localparam logic [3:0] FORM_FWDREV_POS = 4'h1;
	localparam logic [3:0] FORM_QUAD_X1 = 4'h2;
	localparam logic [3:0] FORM_QUAD_X2 = 4'h3;
	localparam logic [3:0] FORM_QUAD_X4 = 4'h4;
	localparam logic [3:0] FORM_SIGN_NEG = 4'h5;
	localparam logic [3:0] FORM_FWDREV_NEG = 4'h6;
	// Filter codes
	localparam logic [3:0] FILT_LINE_1M = 4'h0;
	localparam logic [3:0] FILT_OPEN_200K = 4'h1;
	localparam logic [3:0] FILT_LINE_4M = 4'h2;
	// Clock and filter timing
	localparam int CLK_MHZ = 100;
	localparam int FILT_1M_NS = 100;
	localparam int FILT_200K_NS = 1000;
	localparam int FILT_4M_NS = 30;
	localparam int FILT_1M_CYC = FILT_1M_NS * CLK_MHZ / 1000;
	localparam int FILT_200K_CYC = FILT_200K_NS * CLK_MHZ / 1000;
	localparam int FILT_4M_CYC = FILT_4M_NS * CLK_MHZ / 1000;
	localparam int FILT_W = 7;
	localparam int POS_W = 32;
	localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
endpackage

// ### sim/ptd_host_model.sv
// Host controller model: drives the two reference lines of the decoder.
// Assumes ref_clk_i at 100 MHz; the bench calls its tasks directly.
`timescale 1ns/1ps
module ptd_host_model
	import ptd_pkg::*;
(
	// Clock
	input wire logic ref_clk_i,
	// Reference lines
	output logic line_a_o,
	output logic line_b_o
);
	initial begin
		line_a_o = 1'b0;
		line_b_o = 1'b0;
	end

	// Idle levels; called while the decoder is held in reset
	task automatic idle(input logic [3:0] form, input logic fwd);
		line_a_o = (form == FORM_SIGN_NEG || form == FORM_FWDREV_NEG);
		line_b_o = (form == FORM_SIGN_POS) ? fwd :
			(form == FORM_SIGN_NEG) ? !fwd : (form == FORM_FWDREV_NEG);
	endtask

	// Toggle one line after h falling edges
	task automatic tog(input logic on_a, input int h);
		repeat (h) @(negedge ref_clk_i);
		if (on_a)
			line_a_o = !line_a_o;
		else
			line_b_o = !line_b_o;
	endtask

	// Sends n pulses or quadrature cycles, never faster than the host limits
	task automatic send(input logic [3:0] form, input logic oc, input logic fwd,
		input int n, input int half);
		int h;
		logic quad;
		quad = form inside {FORM_QUAD_X1, FORM_QUAD_X2, FORM_QUAD_X4};
		h = quad ? 25 : 13;
		if (oc && h < 250)
			h = 250;
		if (half > h)
			h = half;
		repeat (n) begin
			if (quad) begin
				// Forward moves B first: B leads A by a quarter cycle
				tog(!fwd, h);
				tog(fwd, h);
				tog(!fwd, h);
				tog(fwd, h);
			end else begin
				tog((form == FORM_FWDREV_POS || form == FORM_FWDREV_NEG) ? !fwd : 1'b1, h);
				tog((form == FORM_FWDREV_POS || form == FORM_FWDREV_NEG) ? !fwd : 1'b1, h);
			end
		end
	endtask
endmodule

// ### sim/test_pulse_train_reference_decoder.sv
// Self-checking bench for the pulse train reference decoder.
// Assumes the decoder latches its configuration at each reset.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module test_pulse_train_reference_decoder
	import ptd_pkg::*;
;
	typedef struct {logic [3:0] ctrl; logic [3:0] form; logic [3:0] filt; logic fwd; int n;
		int exp_pos;} ptd_row_s;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] ctrl_r = 4'h1;
	logic [3:0] form_r = 4'h0;
	logic [3:0] filt_r = 4'h0;
	logic line_a;
	logic line_b;
	logic fwd_step_o;
	logic rev_step_o;
	logic active_o;
	logic cfg_error_o;
	logic signed [POS_W-1:0] position_o;
	int mismatches = 0;
	int checked = 0;
	int nf = 0;
	int nr = 0;
	ptd_row_s rows [17] = '{
		'{4'h1, 4'h0, 4'h0, 1'b1, 3, 3}, '{4'h1, 4'h0, 4'h0, 1'b0, 2, -2},
		'{4'h1, 4'h5, 4'h0, 1'b1, 3, 3}, '{4'h1, 4'h5, 4'h0, 1'b0, 2, -2},
		'{4'h1, 4'h1, 4'h0, 1'b1, 2, 2}, '{4'h1, 4'h1, 4'h0, 1'b0, 2, -2},
		'{4'h1, 4'h6, 4'h0, 1'b1, 2, 2}, '{4'h1, 4'h6, 4'h0, 1'b0, 2, -2},
		'{4'h1, 4'h2, 4'h0, 1'b1, 2, 2}, '{4'h1, 4'h2, 4'h0, 1'b0, 2, -2},
		'{4'h1, 4'h3, 4'h0, 1'b1, 2, 4}, '{4'h1, 4'h4, 4'h0, 1'b0, 2, -8},
		'{4'h1, 4'h0, 4'h1, 1'b1, 2, 2}, '{4'h1, 4'h4, 4'h2, 1'b1, 1, 4},
		'{4'h0, 4'h0, 4'h0, 1'b1, 3, 0}, '{4'h1, 4'h7, 4'h0, 1'b1, 2, 0},
		'{4'h1, 4'h0, 4'h3, 1'b0, 1, -1}};

	always #5 ref_clk_i = !ref_clk_i;

	// Counted mid-cycle, away from the edge that launches the steps
	always @(negedge ref_clk_i) begin
		if (fwd_step_o === 1'b1)
			nf++;
		if (rev_step_o === 1'b1)
			nr++;
	end

	ptd_host_model host (
		.ref_clk_i(ref_clk_i),
		.line_a_o(line_a),
		.line_b_o(line_b)
	);

	ptd_decoder DUT (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.control_method_select_i(ctrl_r),
		.pulse_form_select_i(form_r),
		.filter_select_i(filt_r),
		.pulse_line_i(line_a),
		.sign_line_i(line_b),
		.fwd_step_o(fwd_step_o),
		.rev_step_o(rev_step_o),
		.active_o(active_o),
		.cfg_error_o(cfg_error_o),
		.position_o(position_o)
	);

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// New configuration only takes effect through a reset
	task automatic restart(input ptd_row_s r);
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		ctrl_r = r.ctrl;
		form_r = r.form;
		filt_r = r.filt;
		host.idle(r.form, r.fwd);
		repeat (3) @(negedge ref_clk_i);
		rst_i = 1'b0;
		// Lets the filter absorb the idle levels before the first pulse;
		// a short stand-in for the host's settle time after enable
		repeat (150) @(negedge ref_clk_i);
		nf = 0;
		nr = 0;
	endtask

	task automatic run_row(input ptd_row_s r);
		int c;
		logic signed [POS_W-1:0] ep;
		c = (r.exp_pos < 0) ? -r.exp_pos : r.exp_pos;
		ep = POS_W'(r.exp_pos);
		restart(r);
		host.send(r.form, r.filt == FILT_OPEN_200K, r.fwd, r.n, 0);
		repeat (300) @(negedge ref_clk_i);
		`CHK("position", ep, position_o)
		`CHK("fwd steps", r.fwd ? c : 0, nf)
		`CHK("rev steps", r.fwd ? 0 : c, nr)
		`CHK("active", 1'(r.ctrl == CTRL_POSITION && r.form <= FORM_FWDREV_NEG), active_o)
		`CHK("cfg error", 1'(r.form > FORM_FWDREV_NEG || r.filt > FILT_LINE_4M), cfg_error_o)
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk_i);
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (12) @(negedge ref_clk_i);
		`CHK("reset position", POS_RESET, position_o)
		`CHK("reset active", 1'b0, active_o)
		rst_i = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		// A short glitch under the open-collector filter, and a late config change
		restart(rows[12]);
		form_r = 4'h7;
		host.tog(1'b1, 5);
		host.tog(1'b1, 50);
		repeat (300) @(negedge ref_clk_i);
		`CHK("glitch position", POS_RESET, position_o)
		host.send(FORM_SIGN_POS, 1'b1, 1'b1, 1, 0);
		repeat (300) @(negedge ref_clk_i);
		`CHK("late config position", 32'sh0000_0001, position_o)
		$display("glitch test done");
		wrap_up();
	end
endmodule
